// >>> hdl/tcc_pkg.sv
package tcc_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LINE_CTL = 8'h00;
   localparam logic [7:0] ADDR_DRP_CTL = 8'h04;
   localparam logic [7:0] ADDR_DRP_TIME = 8'h08;
   localparam logic [7:0] ADDR_DRP_DUTY = 8'h0C;
   localparam logic [7:0] ADDR_MATCH_DB = 8'h10;
   localparam logic [7:0] ADDR_SWAP_CTL = 8'h14;
   localparam logic [7:0] ADDR_SWAP_DB = 8'h18;
   localparam logic [7:0] ADDR_SWAP_TXLEN = 8'h1C;
   localparam logic [7:0] ADDR_CC_SMPL = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_CA_CTL = 8'h28;
   localparam logic [7:0] ADDR_VCONN_OC = 8'h2C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   // line_control_register
   localparam int LC_RP_LO = 0;          // advertisement_level_field [1:0]
   localparam int LC_ROLE = 2;           // 0 sink, 1 source
   localparam int LC_PD1_TRIM = 3;
   localparam int LC_PD2_TRIM = 4;
   localparam int LC_DB_PD = 5;          // dead_battery_pulldown_enable
   localparam int LC_VCONN1 = 6;
   localparam int LC_VCONN2 = 7;
   localparam int LC_AUTO_BD = 8;
   localparam int LC_AUTO_DIS = 9;
   localparam logic [31:0] LC_RESET = 32'h0000_0020;
   // drp control
   localparam int DC_EN = 0;
   localparam int DC_RAND = 1;
   localparam int DC_SRC_FIRST = 2;
   // swap control
   localparam int SC_DET_EN = 0;
   localparam int SC_REQ = 1;
   localparam int SC_LINE = 2;
   localparam int SC_PIN_EN = 3;
   localparam int SC_PIN_LO = 4;         // swap_request_pin_select [7:4]
   localparam int SC_THR_LO = 8;         // swap threshold select [10:8]
   // status
   localparam int ST_ATTACH = 0;
   localparam int ST_SWAP_RCV = 1;
   localparam int ST_VCONN_OC = 2;
   localparam int ST_SWAP_TX = 3;
   // collision avoidance control
   localparam int CA_EN = 0;
   localparam int CA_LINE = 1;
   localparam int CA_THR_LO = 2;         // [4:2]

   // ----------------------------------------------------------------
   // Advertisement encodings and thresholds
   // ----------------------------------------------------------------
   localparam logic [1:0] RP_OFF = 2'h0;
   localparam logic [1:0] RP_DEF = 2'h1;
   localparam logic [1:0] RP_1A5 = 2'h2;
   localparam logic [1:0] RP_3A0 = 2'h3;
   localparam logic [2:0] THR_TX_NG = 3'h2;
   localparam logic [2:0] THR_TX_OK = 3'h4;

   // ----------------------------------------------------------------
   // Timing (slow clock 20 kHz derived from 20 MHz)
   // ----------------------------------------------------------------
   localparam int SYS_HZ = 20000000;
   localparam int SLOW_HZ = 20000;
   localparam int SLOW_DIV = SYS_HZ / SLOW_HZ;
   localparam int LFSR_STEP_US = 100;
   localparam int LFSR_STEP_TICKS = LFSR_STEP_US * SLOW_HZ / 1000000;
   localparam int DRP_MIN_MS = 50;
   localparam int DRP_MAX_MS = 100;
   localparam logic [11:0] DRP_MIN_TICKS = 12'(DRP_MIN_MS * SLOW_HZ / 1000);
   localparam logic [11:0] DRP_MAX_TICKS = 12'(DRP_MAX_MS * SLOW_HZ / 1000);
   localparam logic [11:0] LFSR_SEED = 12'h0ACE;

   typedef enum logic [1:0] {
      FRS_ROTATE = 2'b00,
      FRS_PARK = 2'b01
   } tcc_frs_t;
endpackage : tcc_pkg

// >>> hdl/tcc_ctrl.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R01] Steer Rp current off during config sampling
// [R02] Sink role: Rd both lines, VBUS attach
// [R03] Toggle alternates Rp and Rd per period/duty
// [R04] Period fixed or random; selectable first phase
// [R05] Debounced match reports attach, stops toggle
// [R06] Firmware re-debounces then re-enables toggle
// [R07] LFSR on slow clock steps every 100us
// [R08] Clamp toggle period to 50-100 ms
// [R09] Source Rp 3A sink may send, 1.5A not
// [R10] Collision mode samples one threshold, one line
// [R11] Swap detect rotates three thresholds, high bandwidth
// [R12] Swap match parks and samples at 12 MHz; code samples on every 20 MHz system cycle
// [R13] Parked debounce sets swap status then resumes
// [R14] Pin override: swap, VBUS, or both ANDed
// [R15] Partner circuitry supplies VBUS within deadline
// [R16] Source swap request pulls line low timed
// [R17] Request bit self clears; pin selectable
// [R18] Swap signalling overrides PD MAC transmit
// [R19] Swap line latched until transmission ends
// [R20] Dead-battery pulldown defaults on, swapped by software
// [R21] Separate VCONN FET bits, never both
// [R22] Qualified overcurrent disables FET; optional auto disable
// [R23] Rp field: off, default, 1.5A, 3A
module tcc_ctrl (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CFG_SAMPLING,
   input wire logic VBUS_PRESENT,
   input wire logic VBUS_SAFE0V,
   input wire logic VBUS_THR_MATCH,
   input wire logic CC_CMP_OUT,
   input wire logic VCONN_OC,
   input wire logic BACKDRIVE_ERR,
   input wire logic DISCHARGE_ERR,
   input wire logic [15:0] GPIO_IN,
   input wire logic [1:0] OVR_SEL,
   input wire logic PD_TX_EN_IN,
   output logic PD_TX_EN,
   output logic [1:0] RP_CC1,
   output logic [1:0] RP_CC2,
   output logic RD_TRIM_CC1,
   output logic RD_TRIM_CC2,
   output logic RD_DB_EN,
   output logic SWAP_PD_CC1,
   output logic SWAP_PD_CC2,
   output logic VCONN1_EN,
   output logic VCONN2_EN,
   output logic [2:0] CMP_THR,
   output logic CMP_LINE,
   output logic CMP_HIBW,
   output logic PIN_OVR,
   output logic IRQ_N
);
   import tcc_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NS = 8;
   logic [NS-1:0] s1_r, s2_r;
   logic [15:0] g1_r, g2_r;
   // Each pin is synchronised alone; no gate sits ahead of the first flop
   wire [NS-1:0] raw = {CFG_SAMPLING, VBUS_PRESENT, VBUS_SAFE0V, VBUS_THR_MATCH,
                        CC_CMP_OUT, VCONN_OC, BACKDRIVE_ERR, DISCHARGE_ERR};
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         s1_r <= '0;
         s2_r <= '0;
         g1_r <= '0;
         g2_r <= '0;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         g1_r <= GPIO_IN;
         g2_r <= g1_r;
      end
   end
   wire cfg_smp = s2_r[7];
   wire vbus_on = s2_r[6];
   wire vbus_0v = s2_r[5];
   wire vbus_thr = s2_r[4];
   wire cmp = s2_r[3];
   wire oc = s2_r[2];
   wire bd = s2_r[1];
   wire dis = s2_r[0];

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] lc_r, dc_r, swc_r, ca_r, st_r;
   logic [11:0] drp_time_r, match_db_r, swap_db_r, swap_len_r, oc_q_r;
   logic [7:0] duty_r, smpl_r;
   wire wr = PSEL & PENABLE & PWRITE;
   wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
   wire hit_lc = PADDR == ADDR_LINE_CTL;
   wire hit_dc = PADDR == ADDR_DRP_CTL;
   wire hit_dt = PADDR == ADDR_DRP_TIME;
   wire hit_du = PADDR == ADDR_DRP_DUTY;
   wire hit_md = PADDR == ADDR_MATCH_DB;
   wire hit_sc = PADDR == ADDR_SWAP_CTL;
   wire hit_sd = PADDR == ADDR_SWAP_DB;
   wire hit_sl = PADDR == ADDR_SWAP_TXLEN;
   wire hit_cs = PADDR == ADDR_CC_SMPL;
   wire hit_st = PADDR == ADDR_STATUS;
   wire hit_ca = PADDR == ADDR_CA_CTL;
   wire hit_oc = PADDR == ADDR_VCONN_OC;
   wire mapped = hit_lc | hit_dc | hit_dt | hit_du | hit_md | hit_sc | hit_sd | hit_sl |
                 hit_cs | hit_st | hit_ca | hit_oc;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;

   logic [31:0] rdata;
   always_comb begin
      if (hit_lc) rdata = lc_r;
      else if (hit_dc) rdata = dc_r;
      else if (hit_dt) rdata = {20'h0_0000, drp_time_r};
      else if (hit_du) rdata = {24'h00_0000, duty_r};
      else if (hit_md) rdata = {20'h0_0000, match_db_r};
      else if (hit_sc) rdata = swc_r;
      else if (hit_sd) rdata = {20'h0_0000, swap_db_r};
      else if (hit_sl) rdata = {20'h0_0000, swap_len_r};
      else if (hit_cs) rdata = {24'h00_0000, smpl_r};
      else if (hit_st) rdata = st_r;
      else if (hit_ca) rdata = ca_r;
      else if (hit_oc) rdata = {20'h0_0000, oc_q_r};
      else rdata = 32'h0000_0000;
   end
   // Read data is loaded in the setup cycle so it stands through access
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) PRDATA <= 32'h0000_0000;
      else if (rd_setup) PRDATA <= rdata;
   end

   // ----------------------------------------------------------------
   // Slow tick divider
   // ----------------------------------------------------------------
   logic [15:0] div_r;
   wire slow = div_r == 16'(SLOW_DIV - 1);
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || slow) div_r <= '0;
      else div_r <= div_r + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Random period and clamp
   // ----------------------------------------------------------------
   function automatic logic [11:0] clamp(input logic [11:0] v);
      if (v < DRP_MIN_TICKS) clamp = DRP_MIN_TICKS;
      else if (v > DRP_MAX_TICKS) clamp = DRP_MAX_TICKS;
      else clamp = v;
   endfunction : clamp

   logic [11:0] lfsr_r;
   logic [3:0] lstep_r;
   wire drp_en = dc_r[DC_EN];
   wire lstep = slow && lstep_r == 4'(LFSR_STEP_TICKS - 1);
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         lfsr_r <= LFSR_SEED;
         lstep_r <= '0;
      end else if (slow && drp_en && dc_r[DC_RAND]) begin
         lstep_r <= lstep ? 4'h0 : lstep_r + 4'h1;
         if (lstep) lfsr_r <= {lfsr_r[10:0], lfsr_r[11] ^ lfsr_r[5] ^ lfsr_r[3] ^ lfsr_r[0]}; // [R07]
      end
   end
   // Random value mapped into the legal window
   wire [11:0] rand_p = DRP_MIN_TICKS + {3'b000, lfsr_r[8:0]};
   wire [11:0] period = clamp(dc_r[DC_RAND] ? rand_p : drp_time_r); // [R04] [R08]
   wire [19:0] src_prod = period * duty_r;
   wire [11:0] src_len = src_prod[19:8];

   // ----------------------------------------------------------------
   // Toggle and attach debounce
   // ----------------------------------------------------------------
   logic [11:0] ph_r, mdb_r;
   wire first_src = dc_r[DC_SRC_FIRST];
   // Source phase is the first src_len ticks when source starts first
   wire in_first = ph_r < src_len;
   wire drp_src = first_src ? in_first : ~(ph_r < (period - src_len)); // [R03]
   wire as_src = drp_en ? drp_src : lc_r[LC_ROLE];
   wire match_ok = as_src ? (cmp & vbus_0v) : vbus_on; // [R05] [R02]
   wire attach = drp_en && slow && match_ok && mdb_r >= match_db_r;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || !drp_en) begin
         ph_r <= '0;
         mdb_r <= '0;
      end else if (slow) begin
         ph_r <= (ph_r >= period - 12'h001) ? 12'h000 : ph_r + 12'h001; // [R03]
         mdb_r <= match_ok ? mdb_r + 12'h001 : 12'h000;
      end
   end

   // ----------------------------------------------------------------
   // Swap detection as sink
   // ----------------------------------------------------------------
   tcc_frs_t frs_r;
   logic [1:0] rot_r;
   logic [7:0] sdiv_r;
   logic [11:0] sdb_r;
   wire det_en = swc_r[SC_DET_EN];
   wire [2:0] swap_thr = swc_r[SC_THR_LO +: 3];
   wire smpl_tick = sdiv_r >= smpl_r;
   wire park = frs_r == FRS_PARK;
   wire swap_ok = park && cmp && sdb_r >= swap_db_r;
   wire swap_fail = park && !cmp;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || !det_en) begin
         frs_r <= FRS_ROTATE;
         rot_r <= '0;
         sdiv_r <= '0;
         sdb_r <= '0;
      end else begin
         case (frs_r)
            FRS_ROTATE: begin
               sdiv_r <= smpl_tick ? 8'h00 : sdiv_r + 8'h01;
               sdb_r <= '0;
               if (smpl_tick) begin
                  if (rot_r == 2'd2 && cmp) frs_r <= FRS_PARK; // [R12]
                  else rot_r <= (rot_r == 2'd2) ? 2'd0 : rot_r + 2'd1; // [R11]
               end
            end
            FRS_PARK: begin
               // Every system cycle is a fast sample here
               sdb_r <= sdb_r + 12'h001; // [R12]
               if (swap_ok || swap_fail) begin
                  frs_r <= FRS_ROTATE; // [R13]
                  rot_r <= '0;
               end
            end
            default: frs_r <= FRS_ROTATE;
         endcase
      end
   end
   wire [2:0] rot_thr = (rot_r == 2'd0) ? THR_TX_OK : (rot_r == 2'd1) ? THR_TX_NG : swap_thr;
   wire ca_en = ca_r[CA_EN];
   assign CMP_THR = det_en ? (park ? swap_thr : rot_thr) :
                    ca_en ? ca_r[CA_THR_LO +: 3] : THR_TX_OK; // [R10] [R13]
   assign CMP_LINE = ca_en ? ca_r[CA_LINE] : 1'b0; // [R10]
   assign CMP_HIBW = det_en; // [R11]
   wire swap_seen = park & cmp;
   wire ovr_swap = OVR_SEL == 2'd0;
   wire ovr_vbus = OVR_SEL == 2'd1;
   assign PIN_OVR = ovr_swap ? swap_seen :
                    ovr_vbus ? vbus_thr : (vbus_thr & swap_seen); // [R14]

   // ----------------------------------------------------------------
   // Swap request as source
   // ----------------------------------------------------------------
   logic tx_act_r, tx_line_r, pin_d_r;
   logic [11:0] tx_cnt_r;
   wire pin_lvl = g2_r[swc_r[SC_PIN_LO +: 4]]; // [R17]
   wire pin_rise = swc_r[SC_PIN_EN] & pin_lvl & ~pin_d_r;
   // Request bit stays set until the pulldown has been sent
   wire tx_start = !tx_act_r && (swc_r[SC_REQ] || pin_rise); // [R16]
   wire tx_done = tx_act_r && slow && tx_cnt_r >= swap_len_r;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         tx_act_r <= 1'b0;
         tx_line_r <= 1'b0;
         tx_cnt_r <= '0;
         pin_d_r <= 1'b0;
      end else begin
         pin_d_r <= pin_lvl;
         if (tx_start) begin
            tx_act_r <= 1'b1;
            tx_line_r <= swc_r[SC_LINE]; // [R19]
            tx_cnt_r <= '0;
         end else if (tx_done) tx_act_r <= 1'b0;
         else if (tx_act_r && slow) tx_cnt_r <= tx_cnt_r + 12'h001; // [R16]
      end
   end
   assign SWAP_PD_CC1 = tx_act_r & ~tx_line_r; // [R19]
   assign SWAP_PD_CC2 = tx_act_r & tx_line_r;
   assign PD_TX_EN = PD_TX_EN_IN & ~tx_act_r; // [R18]

   // ----------------------------------------------------------------
   // VCONN overcurrent qualification
   // ----------------------------------------------------------------
   logic [11:0] occ_r;
   wire oc_hit = slow && oc && occ_r >= oc_q_r;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || !oc) occ_r <= '0;
      else if (slow && occ_r != 12'hFFF) occ_r <= occ_r + 12'h001;
   end
   wire bd_off = bd & lc_r[LC_AUTO_BD];
   wire dis_off = dis & lc_r[LC_AUTO_DIS];
   wire auto_off = oc_hit | bd_off | dis_off; // [R22]

   // ----------------------------------------------------------------
   // Register writes and status
   // ----------------------------------------------------------------
   wire [3:0] ev = {tx_done, oc_hit, swap_ok, attach};
   wire wr_lc = wr & hit_lc;
   wire wr_dc = wr & hit_dc;
   wire wr_dt = wr & hit_dt;
   wire wr_du = wr & hit_du;
   wire wr_md = wr & hit_md;
   wire wr_sc = wr & hit_sc;
   wire wr_sd = wr & hit_sd;
   wire wr_sl = wr & hit_sl;
   wire wr_cs = wr & hit_cs;
   wire wr_ca = wr & hit_ca;
   wire wr_oc = wr & hit_oc;
   // Write one to clear; a new event in the same cycle wins
   wire [3:0] st_clr = (wr & hit_st) ? PWDATA[3:0] : 4'h0;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         lc_r <= LC_RESET; // [R20]
         dc_r <= '0;
         swc_r <= '0;
         ca_r <= '0;
         st_r <= '0;
         drp_time_r <= DRP_MIN_TICKS;
         duty_r <= 8'h80;
         match_db_r <= 12'h004;
         swap_db_r <= 12'h010;
         swap_len_r <= 12'h002;
         smpl_r <= 8'h14;
         oc_q_r <= 12'h004;
      end else begin
         if (wr_lc) lc_r <= PWDATA & 32'h0000_03FF; // [R20] [R21]
         else if (auto_off) begin
            lc_r[LC_VCONN1] <= 1'b0; // [R22]
            lc_r[LC_VCONN2] <= 1'b0;
         end
         if (attach) dc_r[DC_EN] <= 1'b0; // [R05]
         else if (wr_dc) dc_r <= PWDATA & 32'h0000_0007; // [R06]
         if (wr_sc) swc_r <= PWDATA & 32'h0000_07FF;
         else if (tx_done) swc_r[SC_REQ] <= 1'b0; // [R17]
         if (wr_ca) ca_r <= PWDATA & 32'h0000_001F;
         if (wr_dt) drp_time_r <= PWDATA[11:0];
         if (wr_du) duty_r <= PWDATA[7:0];
         if (wr_md) match_db_r <= PWDATA[11:0];
         if (wr_sd) swap_db_r <= PWDATA[11:0];
         if (wr_sl) swap_len_r <= PWDATA[11:0];
         if (wr_cs) smpl_r <= PWDATA[7:0];
         if (wr_oc) oc_q_r <= PWDATA[11:0];
         st_r[3:0] <= (st_r[3:0] & ~st_clr) | ev; // [R13]
      end
   end

   // ----------------------------------------------------------------
   // Terminations
   // ----------------------------------------------------------------
   wire [1:0] rp_lvl = (as_src && !cfg_smp) ? lc_r[LC_RP_LO +: 2] : RP_OFF; // [R01] [R09] [R23]
   wire sink_term = ~as_src; // [R02]
   assign RP_CC1 = rp_lvl;
   assign RP_CC2 = rp_lvl;
   assign RD_TRIM_CC1 = sink_term & lc_r[LC_PD1_TRIM];
   assign RD_TRIM_CC2 = sink_term & lc_r[LC_PD2_TRIM];
   assign RD_DB_EN = lc_r[LC_DB_PD]; // [R20]
   assign VCONN1_EN = lc_r[LC_VCONN1] & ~lc_r[LC_VCONN2]; // [R21]
   assign VCONN2_EN = lc_r[LC_VCONN2] & ~lc_r[LC_VCONN1];
   assign IRQ_N = ~(|st_r[3:0]); // [R05]
endmodule : tcc_ctrl
`default_nettype wire

// >>> tb/tcc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl_sva #(parameter int OC_LIM = 7000) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [7:0] PADDR,
   input wire logic PSLVERR,
   input wire logic PREADY,
   input wire logic CFG_SAMPLING,
   input wire logic VBUS_THR_MATCH,
   input wire logic VCONN_OC,
   input wire logic [1:0] OVR_SEL,
   input wire logic PD_TX_EN,
   input wire logic [1:0] RP_CC1,
   input wire logic [1:0] RP_CC2,
   input wire logic RD_TRIM_CC1,
   input wire logic RD_TRIM_CC2,
   input wire logic RD_DB_EN,
   input wire logic SWAP_PD_CC1,
   input wire logic SWAP_PD_CC2,
   input wire logic VCONN1_EN,
   input wire logic VCONN2_EN,
   input wire logic PIN_OVR,
   input wire logic IRQ_N
);
   logic [13:0] oc_cnt;
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);
   // Cycles of overcurrent while a FET is still on
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN || !VCONN_OC || !(VCONN1_EN || VCONN2_EN)) begin
         oc_cnt <= 14'h0000;
      end else begin
         oc_cnt <= oc_cnt + 14'h0001;
      end
   end
   a_cfg_rp_off: assert property (CFG_SAMPLING [*3] |=> RP_CC1 == 2'h0 && RP_CC2 == 2'h0)
      else $error("Rp advertised while config pin sampled");
   a_rp_rd_excl: assert property ((RP_CC1 != 2'h0) |-> !RD_TRIM_CC1 && !RD_TRIM_CC2)
      else $error("Rp and Rd applied together");
   a_vconn_single: assert property (!(VCONN1_EN && VCONN2_EN))
      else $error("both VCONN FETs on");
   a_swap_mac: assert property ((SWAP_PD_CC1 || SWAP_PD_CC2) |-> !PD_TX_EN)
      else $error("MAC transmit during swap pulldown");
   a_swap_line: assert property (SWAP_PD_CC1 |=> !SWAP_PD_CC2)
      else $error("swap pulldown moved lines");
   a_swap_len: assert property ($rose(SWAP_PD_CC1 || SWAP_PD_CC2) |=> (SWAP_PD_CC1 || SWAP_PD_CC2) [*8])
      else $error("swap pulldown too short");
   a_apb_err: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h2C || PADDR[1:0] != 2'h0))
      else $error("slave error does not follow address map");
   a_reset_vals: assert property ($rose(RSTN) |-> RD_DB_EN && IRQ_N && PREADY)
      else $error("wrong output value after reset");
   a_ovr_vbus: assert property ((OVR_SEL == 2'h1 && VBUS_THR_MATCH) [*3] |-> PIN_OVR)
      else $error("pin override misses VBUS match");
   a_oc_off: assert property (oc_cnt < 14'(OC_LIM))
      else $error("FET left on under overcurrent");
endmodule : tcc_ctrl_sva
bind tcc_ctrl tcc_ctrl_sva u_sva (.*);
`default_nettype wire

// >>> tb/tcc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_partner #(parameter logic [2:0] SWAP_THR = 3'h6) (
   input wire logic [1:0] rp_cc1,
   input wire logic [1:0] rp_cc2,
   input wire logic [2:0] cmp_thr,
   input wire logic [1:0] mode,
   output logic cc_out,
   output logic vbus_low,
   output logic vbus_on
);
   // Mode 1: sink with Rd, matches only while Rp is advertised
   // Mode 2: source pulling CC low, seen only at the swap threshold
   assign cc_out = (mode == 2'h1) ? (rp_cc1 != 2'h0 || rp_cc2 != 2'h0)
      : (mode == 2'h2) && (cmp_thr == SWAP_THR);
   // A sink partner never drives VBUS
   assign vbus_low = (mode != 2'h2);
   assign vbus_on = (mode == 2'h2);
endmodule : tcc_partner
`default_nettype wire

// >>> tb/tcc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl_bench;
   import tcc_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RSTN = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic CFG_SAMPLING = 1'b0;
   logic VBUS_THR_MATCH = 1'b0;
   logic VCONN_OC = 1'b0;
   logic BACKDRIVE_ERR = 1'b0;
   logic DISCHARGE_ERR = 1'b0;
   logic [15:0] GPIO_IN = 16'h0000;
   logic [1:0] OVR_SEL = 2'h0;
   logic PD_TX_EN_IN = 1'b1;
   logic [1:0] mode = 2'h0;
   logic VBUS_PRESENT, VBUS_SAFE0V, CC_CMP_OUT, PREADY, PSLVERR, PD_TX_EN;
   logic RD_TRIM_CC1, RD_TRIM_CC2, RD_DB_EN, SWAP_PD_CC1, SWAP_PD_CC2;
   logic VCONN1_EN, VCONN2_EN, CMP_LINE, CMP_HIBW, PIN_OVR, IRQ_N, err;
   logic [1:0] RP_CC1, RP_CC2;
   logic [2:0] CMP_THR;
   logic [3:0] e;
   logic [7:0] seen;
   logic [31:0] PRDATA, rdat, v;
   logic [31:0] seed = 32'h1a02_e2aa;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int i, n;
   logic [31:0] mdl [12] = '{32'h0000_0020, 32'h0000_0000, 32'h0000_03E8, 32'h0000_0080,
      32'h0000_0004, 32'h0000_0000, 32'h0000_0010, 32'h0000_0002, 32'h0000_0014,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0004};

   tcc_ctrl dut (.*);
   tcc_partner pm (.rp_cc1(RP_CC1), .rp_cc2(RP_CC2), .cmp_thr(CMP_THR), .mode(mode),
      .cc_out(CC_CMP_OUT), .vbus_low(VBUS_SAFE0V), .vbus_on(VBUS_PRESENT));

   initial begin
      forever #25 SYS_CLK = ~SYS_CLK;
   end

   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // Setup, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      err = PSLVERR;
      rdat = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(negedge SYS_CLK);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         test_done();
      end
   end

   initial begin
      repeat (20) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      for (i = 0; i < 12; i++) begin
         rd(8'(i * 4));
         chk(rdat, mdl[i]);
      end
      rd(8'h30);
      chk({rdat[30:0], err}, 32'h0000_0001);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         seed = nx(seed);
         @(posedge SYS_CLK) GPIO_IN <= seed[15:0];
         v = (seed & 32'h0000_03F8) | 32'(i);
         wr(ADDR_LINE_CTL, v);
         mdl[0] = v;
         rd(ADDR_LINE_CTL);
         chk(rdat, mdl[0]);
         chk(32'({RP_CC1, RP_CC2}), 32'(v[2] ? {v[1:0], v[1:0]} : 4'h0));
         e = {~v[2] & v[3], v[5], v[6] & ~v[7], v[7] & ~v[6]};
         chk(32'({RD_TRIM_CC1, RD_DB_EN, VCONN1_EN, VCONN2_EN}), 32'(e));
      end
      wr(ADDR_LINE_CTL, 32'h0000_0007);
      @(posedge SYS_CLK) CFG_SAMPLING <= 1'b1;
      GPIO_IN <= 16'h0000;
      repeat (5) @(posedge SYS_CLK);
      chk(32'({RP_CC1, RP_CC2}), 32'h0000_0000);
      CFG_SAMPLING <= 1'b0;
      repeat (5) @(posedge SYS_CLK);
      chk(32'(RP_CC1), 32'h0000_0003);
      wr(ADDR_CA_CTL, 32'h0000_0013);
      chk(32'({CMP_LINE, CMP_THR}), 32'h0000_000C);
      wr(ADDR_CA_CTL, 32'h0000_0000);
      @(posedge SYS_CLK) VBUS_THR_MATCH <= 1'b1;
      OVR_SEL <= 2'h1;
      repeat (4) @(posedge SYS_CLK);
      chk(32'(PIN_OVR), 32'h0000_0001);
      OVR_SEL <= 2'h2;
      repeat (2) @(posedge SYS_CLK);
      chk(32'(PIN_OVR), 32'h0000_0000);
      $display("test lines done");
      wr(ADDR_SWAP_CTL, 32'h0000_0006);
      for (n = 0; n < 50 && SWAP_PD_CC2 !== 1'b1; n++) @(posedge SYS_CLK);
      chk(32'({SWAP_PD_CC2, PD_TX_EN}), 32'h0000_0002);
      rd(ADDR_SWAP_CTL);
      chk(rdat, 32'h0000_0006);
      for (n = 0; n < 5000 && SWAP_PD_CC2 !== 1'b0; n++) @(posedge SYS_CLK);
      rd(ADDR_SWAP_CTL);
      chk(rdat, 32'h0000_0004);
      rd(ADDR_STATUS);
      chk(rdat, 32'h0000_0008);
      wr(ADDR_STATUS, 32'h0000_0008);
      wr(ADDR_SWAP_CTL, 32'h0000_0058);
      @(posedge SYS_CLK) GPIO_IN <= 16'h0020;
      for (n = 0; n < 50 && SWAP_PD_CC1 !== 1'b1; n++) @(posedge SYS_CLK);
      chk(32'({SWAP_PD_CC1, SWAP_PD_CC2}), 32'h0000_0002);
      for (n = 0; n < 5000 && SWAP_PD_CC1 !== 1'b0; n++) @(posedge SYS_CLK);
      wr(ADDR_SWAP_CTL, 32'h0000_0000);
      wr(ADDR_STATUS, 32'h0000_0008);
      $display("test swap send done");
      wr(ADDR_LINE_CTL, 32'h0000_0000);
      wr(ADDR_CC_SMPL, 32'h0000_0004);
      wr(ADDR_SWAP_DB, 32'h0000_0040);
      wr(ADDR_SWAP_CTL, 32'h0000_0601);
      seen = 8'h00;
      for (n = 0; n < 100; n++) begin
         @(posedge SYS_CLK);
         seen[CMP_THR] = 1'b1;
      end
      chk(32'({CMP_HIBW, seen}), 32'h0000_0154);
      mode <= 2'h2;
      repeat (20) @(posedge SYS_CLK);
      seen = 8'h00;
      for (n = 0; n < 8; n++) begin
         @(posedge SYS_CLK);
         seen[CMP_THR] = 1'b1;
      end
      chk(32'(seen), 32'h0000_0040);
      for (n = 0; n < 300 && IRQ_N !== 1'b0; n++) @(posedge SYS_CLK);
      mode <= 2'h0;
      rd(ADDR_STATUS);
      chk(rdat, 32'h0000_0002);
      wr(ADDR_STATUS, 32'h0000_0002);
      seen = 8'h00;
      for (n = 0; n < 40; n++) begin
         @(posedge SYS_CLK);
         seen[CMP_THR] = 1'b1;
      end
      chk(32'(seen), 32'h0000_0054);
      wr(ADDR_SWAP_CTL, 32'h0000_0000);
      $display("test swap detect done");
      wr(ADDR_VCONN_OC, 32'h0000_0001);
      wr(ADDR_LINE_CTL, 32'h0000_0040);
      chk(32'(VCONN1_EN), 32'h0000_0001);
      @(posedge SYS_CLK) VCONN_OC <= 1'b1;
      for (n = 0; n < 4000 && VCONN1_EN !== 1'b0; n++) @(posedge SYS_CLK);
      rd(ADDR_STATUS);
      chk(rdat, 32'h0000_0004);
      rd(ADDR_LINE_CTL);
      chk(rdat | 32'(VCONN1_EN), 32'h0000_0000);
      @(posedge SYS_CLK) VCONN_OC <= 1'b0;
      wr(ADDR_STATUS, 32'h0000_0004);
      $display("test overcurrent done");
      wr(ADDR_LINE_CTL, 32'h0000_0001);
      wr(ADDR_MATCH_DB, 32'h0000_0001);
      @(posedge SYS_CLK) mode <= 2'h1;
      wr(ADDR_DRP_CTL, 32'h0000_0005);
      for (n = 0; n < 3000 && RP_CC1 === 2'h0; n++) @(posedge SYS_CLK);
      chk(32'(RP_CC1), 32'h0000_0001);
      for (n = 0; n < 8000 && IRQ_N !== 1'b0; n++) @(posedge SYS_CLK);
      rd(ADDR_STATUS);
      chk(rdat, 32'h0000_0001);
      rd(ADDR_DRP_CTL);
      chk(rdat, 32'h0000_0004);
      @(posedge SYS_CLK) mode <= 2'h0;
      wr(ADDR_STATUS, 32'h0000_0001);
      chk(32'(IRQ_N), 32'h0000_0001);
      wr(ADDR_DRP_CTL, 32'h0000_0003);
      rd(ADDR_DRP_CTL);
      chk(rdat, 32'h0000_0003);
      $display("test attach done");
      test_done();
   end
endmodule : tcc_ctrl_bench
`default_nettype wire
